/* File: include/tmo_pkg.sv */
// constants shared by the timer output and prescale control block
package tmo_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] OFS_OUTCTL = 8'h00;
	localparam logic [7:0] OFS_PRESCALE = 8'h04;
	localparam logic [7:0] OFS_MODE = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_CMP = 8'h10;
	// output_control_reg bit positions
	localparam int OC_TOE = 0;
	localparam int OC_INV0 = 1;
	localparam int OC_LVR = 2;
	localparam int OC_LVS = 3;
	localparam int OC_INV1 = 4;
	localparam int OC_OSPE = 5;
	localparam int OC_OSPT = 6;
	// prescaler_mode_reg fields
	localparam int PM_CLK_LO = 0;
	localparam int PM_EDA_LO = 2;
	localparam int PM_EDB_LO = 4;
	localparam int PM_BITS = 6;
	// mode register fields
	localparam int MD_RUN_LO = 2;
	localparam int MD_PINB_CAP = 4;
	localparam int MD_BITS = 5;
	// status register fields
	localparam int ST_EDGE_A = 16;
	localparam int ST_EDGE_B = 17;
	localparam int ST_OSC = 18;
	// count clock selections
	localparam logic [1:0] CK_DIV2 = 2'h0;
	localparam logic [1:0] CK_DIV8 = 2'h1;
	localparam logic [1:0] CK_DIV32 = 2'h2;
	localparam logic [1:0] CK_EDGE_A = 2'h3;
	// valid edge selections
	localparam logic [1:0] ED_FALL = 2'h0;
	localparam logic [1:0] ED_RISE = 2'h1;
	localparam logic [1:0] ED_NONE = 2'h2;
	localparam logic [1:0] ED_BOTH = 2'h3;
	// run modes
	localparam logic [1:0] RUN_STOP = 2'h0;
	localparam logic [1:0] RUN_FREE = 2'h1;
	localparam logic [1:0] RUN_CLR_EDGE = 2'h2;
	localparam logic [1:0] RUN_CLR_CMP = 2'h3;
	// reset values and limits
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CMP_RESET = 16'hffff;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage : tmo_pkg

/* File: logic/tmo_timer_out_ctrl.sv */
// timer output, one-shot trigger, prescaler and input edge control
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
// Behaviour
// [RL1] output-level set and reset bits always read back as zero
// [RL2] one-shot trigger bit clears itself; reads return zero
// [RL3] software writes trigger only while in one-shot output mode
// [RL4] trigger writes spaced at least two count clock periods
// [RL5] enable output before level set; never both in one write
// [RL6] program output setup first, level bits in a later write
// [RL7] stop counter before writing the prescaler mode register
// [RL8] no clear-on-edge mode while input a edge is the count clock
// [RL9] input high after reset gives rising edge at first enable
// [RL10] re-enable after stop gives no spurious rising edge
// [RL11] shared pin is either capture input b or timer output
// [RL12] internal oscillator clocking is flagged as unsafe
// [RL13] level set forces output high, level reset forces it low
// [RL14] counter runs when run mode is nonzero, stops at zero
module tmo_timer_out_ctrl #(
	parameter int DIV_W = 5
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_input_a,
	input wire logic shared_pin_in,
	output logic shared_pin_out,
	output logic shared_pin_oe,
	input wire logic cpu_on_internal_osc
);
	logic [1:0] a_sync, b_sync, osc_sync;
	logic a_prev, b_prev, has_run;
	logic [DIV_W-1:0] div_cnt;
	logic [15:0] timer_counter_value, compare_reg_b;
	logic [6:0] output_control_reg;
	logic [tmo_pkg::PM_BITS-1:0] prescaler_mode_reg;
	logic [tmo_pkg::MD_BITS-1:0] mode_reg;
	logic out_ff, edge_a_seen, edge_b_seen, osc_unsafe;
	logic [DIV_W-1:0] next_div_cnt;
	logic [15:0] next_timer_counter_value, next_compare_reg_b;
	logic [6:0] next_output_control_reg;
	logic [tmo_pkg::PM_BITS-1:0] next_prescaler_mode_reg;
	logic [tmo_pkg::MD_BITS-1:0] next_mode_reg;
	logic next_out_ff, next_edge_a_seen, next_edge_b_seen, next_a_prev;
	logic next_b_prev, next_has_run, next_pready, next_pslverr;
	logic [31:0] next_prdata;
	logic wr_now, rd_now, mapped, running, tick, hit_a, hit_b, trig;
	logic [1:0] run_mode, clk_sel;

	// pin inputs pass two flops; only the second stage is read
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			a_sync <= 2'h0;
			b_sync <= 2'h0;
			osc_sync <= 2'h0;
		end
		else
		begin
			a_sync <= {a_sync[0], capture_input_a};
			b_sync <= {b_sync[0], shared_pin_in};
			osc_sync <= {osc_sync[0], cpu_on_internal_osc};
		end
	end

	// edge filter per selection; none never hits
	function automatic logic edge_hit(input logic [1:0] sel,
		input logic now, input logic prev);
		edge_hit = ((sel == tmo_pkg::ED_RISE || sel == tmo_pkg::ED_BOTH)
			&& now && !prev) || ((sel == tmo_pkg::ED_FALL
			|| sel == tmo_pkg::ED_BOTH) && !now && prev);
	endfunction : edge_hit

	// decode of bus phases and control fields
	always_comb
	begin
		wr_now = psel && penable && pready && pwrite;
		rd_now = psel && penable && !pready && !pwrite;
		mapped = paddr == tmo_pkg::OFS_OUTCTL
			|| paddr == tmo_pkg::OFS_PRESCALE || paddr == tmo_pkg::OFS_MODE
			|| paddr == tmo_pkg::OFS_STATUS || paddr == tmo_pkg::OFS_CMP;
		run_mode = mode_reg[tmo_pkg::MD_RUN_LO +: 2];
		clk_sel = prescaler_mode_reg[tmo_pkg::PM_CLK_LO +: 2];
		running = run_mode != tmo_pkg::RUN_STOP; // [RL14]
		// edges are honoured only while counting
		hit_a = running && edge_hit(
			prescaler_mode_reg[tmo_pkg::PM_EDA_LO +: 2], a_sync[1], a_prev);
		// pin b edges ignored while the pin drives the timer output
		hit_b = running && mode_reg[tmo_pkg::MD_PINB_CAP] && edge_hit(
			prescaler_mode_reg[tmo_pkg::PM_EDB_LO +: 2],
			b_sync[1], b_prev); // [RL11]
		unique case (clk_sel)
			tmo_pkg::CK_DIV2: tick = div_cnt[0];
			tmo_pkg::CK_DIV8: tick = &div_cnt[2:0];
			tmo_pkg::CK_DIV32: tick = &div_cnt;
			tmo_pkg::CK_EDGE_A: tick = hit_a;
		endcase
		// trigger is a pulse and never stored, so it reads back zero
		trig = wr_now && paddr == tmo_pkg::OFS_OUTCTL
			&& pwdata[tmo_pkg::OC_OSPT]
			&& output_control_reg[tmo_pkg::OC_OSPE]; // [RL2]
	end

	// next state of registers, counter, output flop and edge history
	always_comb
	begin
		next_div_cnt = running ? div_cnt + 1'b1 : '0;
		next_output_control_reg = output_control_reg;
		next_prescaler_mode_reg = prescaler_mode_reg;
		next_mode_reg = mode_reg;
		next_compare_reg_b = compare_reg_b;
		next_timer_counter_value = timer_counter_value;
		next_out_ff = out_ff;
		next_edge_a_seen = edge_a_seen;
		next_edge_b_seen = edge_b_seen;
		next_pready = psel && penable && !pready;
		next_pslverr = psel && penable && !pready && !mapped;
		next_prdata = tmo_pkg::DATA_ZERO;
		// prev stays low until the first enable, so a high pin then
		// shows as a rising edge; later it tracks the pin while stopped
		next_has_run = has_run || running;
		next_a_prev = (running || has_run) ? a_sync[1] : 1'b0; // [RL9]
		next_b_prev = (running || has_run) ? b_sync[1] : 1'b0; // [RL10]
		if (rd_now)
		begin
			unique case (paddr)
				tmo_pkg::OFS_OUTCTL:
				begin
					next_prdata[6:0] = output_control_reg;
					next_prdata[tmo_pkg::OC_LVS] = 1'b0; // [RL1]
					next_prdata[tmo_pkg::OC_LVR] = 1'b0; // [RL1]
					next_prdata[tmo_pkg::OC_OSPT] = 1'b0; // [RL2]
				end
				tmo_pkg::OFS_PRESCALE:
					next_prdata[tmo_pkg::PM_BITS-1:0] = prescaler_mode_reg;
				tmo_pkg::OFS_MODE:
					next_prdata[tmo_pkg::MD_BITS-1:0] = mode_reg;
				tmo_pkg::OFS_STATUS:
				begin
					next_prdata[15:0] = timer_counter_value;
					next_prdata[tmo_pkg::ST_EDGE_A] = edge_a_seen;
					next_prdata[tmo_pkg::ST_EDGE_B] = edge_b_seen;
					next_prdata[tmo_pkg::ST_OSC] = osc_unsafe; // [RL12]
				end
				tmo_pkg::OFS_CMP: next_prdata[15:0] = compare_reg_b;
				default: next_prdata = tmo_pkg::DATA_ZERO;
			endcase
		end
		// counting on the selected count clock
		if (running && tick)
		begin
			if (run_mode == tmo_pkg::RUN_CLR_CMP
				&& timer_counter_value == compare_reg_b)
				next_timer_counter_value = '0;
			else
				next_timer_counter_value = timer_counter_value + 1'b1;
			if (output_control_reg[tmo_pkg::OC_INV0]
				&& timer_counter_value == tmo_pkg::CNT_MAX)
				next_out_ff = !next_out_ff;
			if (output_control_reg[tmo_pkg::OC_INV1]
				&& timer_counter_value == compare_reg_b)
				next_out_ff = !next_out_ff;
		end
		// clear on input a edge or on a software trigger; counting goes on only while running
		if ((hit_a && run_mode == tmo_pkg::RUN_CLR_EDGE
			&& clk_sel != tmo_pkg::CK_EDGE_A) || trig)
			next_timer_counter_value = '0;
		if (wr_now)
		begin
			unique case (paddr)
				tmo_pkg::OFS_OUTCTL:
				begin
					// level bits act once and are not kept
					next_output_control_reg = pwdata[6:0];
					next_output_control_reg[tmo_pkg::OC_LVS] = 1'b0;
					next_output_control_reg[tmo_pkg::OC_LVR] = 1'b0;
					next_output_control_reg[tmo_pkg::OC_OSPT] = 1'b0;
					if (pwdata[tmo_pkg::OC_LVR])
						next_out_ff = 1'b0; // [RL13]
					if (pwdata[tmo_pkg::OC_LVS])
						next_out_ff = 1'b1; // [RL13]
				end
				tmo_pkg::OFS_PRESCALE:
					next_prescaler_mode_reg = pwdata[tmo_pkg::PM_BITS-1:0];
				tmo_pkg::OFS_MODE:
					next_mode_reg = pwdata[tmo_pkg::MD_BITS-1:0];
				tmo_pkg::OFS_STATUS:
				begin
					if (pwdata[tmo_pkg::ST_EDGE_A])
						next_edge_a_seen = 1'b0;
					if (pwdata[tmo_pkg::ST_EDGE_B])
						next_edge_b_seen = 1'b0;
				end
				tmo_pkg::OFS_CMP: next_compare_reg_b = pwdata[15:0];
				default: next_compare_reg_b = compare_reg_b;
			endcase
		end
		// a new edge beats a clear in the same cycle
		if (hit_a)
			next_edge_a_seen = 1'b1;
		if (hit_b)
			next_edge_b_seen = 1'b1;
	end

	// state registers; outputs come straight from flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_cnt <= '0;
			output_control_reg <= '0;
			prescaler_mode_reg <= '0;
			mode_reg <= '0;
			compare_reg_b <= tmo_pkg::CMP_RESET;
			timer_counter_value <= '0;
			out_ff <= 1'b0;
			edge_a_seen <= 1'b0;
			edge_b_seen <= 1'b0;
			a_prev <= 1'b0;
			b_prev <= 1'b0;
			has_run <= 1'b0;
			osc_unsafe <= 1'b0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= tmo_pkg::DATA_ZERO;
			shared_pin_out <= 1'b0;
			shared_pin_oe <= 1'b0;
		end
		else
		begin
			div_cnt <= next_div_cnt;
			output_control_reg <= next_output_control_reg;
			prescaler_mode_reg <= next_prescaler_mode_reg;
			mode_reg <= next_mode_reg;
			compare_reg_b <= next_compare_reg_b;
			timer_counter_value <= next_timer_counter_value;
			out_ff <= next_out_ff;
			edge_a_seen <= next_edge_a_seen;
			edge_b_seen <= next_edge_b_seen;
			a_prev <= next_a_prev;
			b_prev <= next_b_prev;
			has_run <= next_has_run;
			// flag only: timing cannot be trusted on that clock
			osc_unsafe <= osc_sync[1]; // [RL12]
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
			shared_pin_out <= next_out_ff;
			shared_pin_oe <= next_output_control_reg[tmo_pkg::OC_TOE]
				&& !next_mode_reg[tmo_pkg::MD_PINB_CAP]; // [RL11]
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_lvl_read_zero;
		pready && !pwrite && paddr == tmo_pkg::OFS_OUTCTL
			|-> !prdata[tmo_pkg::OC_LVS] && !prdata[tmo_pkg::OC_LVR];
	endproperty
	a_lvl_read_zero: assert property (p_lvl_read_zero) // [RL1]
		else $error("level bits read nonzero");
	property p_trig_read_zero;
		pready && !pwrite |-> !(paddr == tmo_pkg::OFS_OUTCTL
			&& prdata[tmo_pkg::OC_OSPT]);
	endproperty
	a_trig_read_zero: assert property (p_trig_read_zero) // [RL2]
		else $error("trigger bit read nonzero");
	property p_set_high;
		wr_now && paddr == tmo_pkg::OFS_OUTCTL && pwdata[tmo_pkg::OC_LVS]
			|=> out_ff ##1 shared_pin_out;
	endproperty
	a_set_high: assert property (p_set_high) // [RL13]
		else $error("level set did not drive output high");
	property p_reset_low;
		wr_now && paddr == tmo_pkg::OFS_OUTCTL && pwdata[tmo_pkg::OC_LVR]
			&& !pwdata[tmo_pkg::OC_LVS] |=> !out_ff;
	endproperty
	a_reset_low: assert property (p_reset_low) // [RL13]
		else $error("level reset did not drive output low");
	property p_stop_holds;
		!running && !trig |=> $stable(timer_counter_value);
	endproperty
	a_stop_holds: assert property (p_stop_holds) // [RL14]
		else $error("counter moved while stopped");
	property p_pin_exclusive;
		shared_pin_oe |-> !mode_reg[tmo_pkg::MD_PINB_CAP];
	endproperty
	a_pin_exclusive: assert property (p_pin_exclusive) // [RL11]
		else $error("timer output driven in capture mode");
	property p_first_enable;
		!has_run |-> !a_prev && !b_prev;
	endproperty
	a_first_enable: assert property (p_first_enable) // [RL9]
		else $error("edge history not low before first enable");
	property p_reenable;
		!running && has_run |=> a_prev == $past(a_sync[1]);
	endproperty
	a_reenable: assert property (p_reenable) // [RL10]
		else $error("edge history not tracking pin while stopped");
	property p_osc_flag;
		osc_sync[1] |=> osc_unsafe;
	endproperty
	a_osc_flag: assert property (p_osc_flag) // [RL12]
		else $error("oscillator flag not raised");
	property p_trig_restart;
		trig |=> timer_counter_value == '0;
	endproperty
	a_trig_restart: assert property (p_trig_restart) // [RL2]
		else $error("trigger did not restart counter");

	c_trigger: cover property (trig);
	c_edge_a: cover property (hit_a && running);
	c_wrap_invert: cover property (running && tick
		&& timer_counter_value == tmo_pkg::CNT_MAX);
	c_slverr: cover property (pready && pslverr);
endmodule : tmo_timer_out_ctrl

/* File: bench/tmo_pin_source.sv */
// far-side pin source: drives capture input a and the shared port pin
`timescale 1ns/1ps
module tmo_pin_source (
	input wire logic clk,
	input wire logic level_a,
	input wire logic level_b,
	input wire logic shared_pin_out,
	input wire logic shared_pin_oe,
	output logic capture_input_a,
	output logic shared_pin_in
);
	// the source only moves its pin just after a clock edge
	always_ff @(posedge clk)
	begin
		capture_input_a <= level_a;
	end
	// wire level: the block owns the pin while enabled, else the source
	assign shared_pin_in = shared_pin_oe ? shared_pin_out : level_b;
endmodule : tmo_pin_source

/* File: bench/tmo_timer_out_ctrl_test.sv */
// self-checking testbench for the timer output and prescale control block
`timescale 1ns/1ps
module tmo_timer_out_ctrl_test;
	localparam logic [31:0] B_TOE = 32'h0000_0001 << tmo_pkg::OC_TOE;
	localparam logic [31:0] B_LVR = 32'h0000_0001 << tmo_pkg::OC_LVR;
	localparam logic [31:0] B_LVS = 32'h0000_0001 << tmo_pkg::OC_LVS;
	localparam logic [31:0] B_OSPE = 32'h0000_0001 << tmo_pkg::OC_OSPE;
	localparam logic [31:0] B_OSPT = 32'h0000_0001 << tmo_pkg::OC_OSPT;
	localparam logic [31:0] B_INV1 = 32'h0000_0001 << tmo_pkg::OC_INV1;
	localparam logic [31:0] B_RUN = 32'(tmo_pkg::RUN_FREE)
		<< tmo_pkg::MD_RUN_LO;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic rerr, lvl_a, lvl_b, cap_a, pin_in, pin_out, pin_oe, osc;
	int fail_count, n_compared, cycles;

	tmo_timer_out_ctrl #(.DIV_W(5)) i_tmo_timer_out_ctrl (.clk(clk),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capture_input_a(cap_a), .shared_pin_in(pin_in),
		.shared_pin_out(pin_out), .shared_pin_oe(pin_oe),
		.cpu_on_internal_osc(osc));
	tmo_pin_source i_tmo_pin_source (.clk(clk), .level_a(lvl_a),
		.level_b(lvl_b), .shared_pin_out(pin_out), .shared_pin_oe(pin_oe),
		.capture_input_a(cap_a), .shared_pin_in(pin_in));

	// free-running 100 MHz clock
	always #5 clk = ~clk;

	task end_of_test;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	// hang guard: the whole run needs well under 2000 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			end_of_test();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask : chk

	task waitc(input int n);
		repeat (n) @(posedge clk);
	endtask : waitc

	// one apb transfer; the request stands until pready is seen high
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no wait-state count assumed; only the hang guard ends this
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task t_reset;
		xfer(1'b0, tmo_pkg::OFS_OUTCTL, 32'h0000_0000);
		chk(rdat, tmo_pkg::DATA_ZERO);
		xfer(1'b0, tmo_pkg::OFS_CMP, 32'h0000_0000);
		chk(rdat, {16'h0000, tmo_pkg::CMP_RESET});
		// unmapped place: refused, reads zero
		xfer(1'b0, 8'h20, 32'h0000_0000);
		chk(32'(rerr), 32'h0000_0001);
		chk(rdat, tmo_pkg::DATA_ZERO);
	endtask : t_reset

	// input a is high from reset, so the first enable sees a rising edge
	task t_edge_a;
		xfer(1'b1, tmo_pkg::OFS_PRESCALE, 32'h0000_0004);
		xfer(1'b1, tmo_pkg::OFS_MODE, B_RUN);
		waitc(6);
		xfer(1'b0, tmo_pkg::OFS_STATUS, 32'h0000_0000);
		chk(32'(rdat[tmo_pkg::ST_EDGE_A]), 32'h0000_0001);
		xfer(1'b1, tmo_pkg::OFS_MODE, 32'h0000_0000);
		xfer(1'b1, tmo_pkg::OFS_STATUS, 32'h0001_0000);
		xfer(1'b1, tmo_pkg::OFS_MODE, B_RUN);
		waitc(6);
		xfer(1'b0, tmo_pkg::OFS_STATUS, 32'h0000_0000);
		chk(32'(rdat[tmo_pkg::ST_EDGE_A]), 32'h0000_0000);
		lvl_a <= 1'b0;
		waitc(6);
		lvl_a <= 1'b1;
		waitc(6);
		xfer(1'b0, tmo_pkg::OFS_STATUS, 32'h0000_0000);
		chk(32'(rdat[tmo_pkg::ST_EDGE_A]), 32'h0000_0001);
		xfer(1'b1, tmo_pkg::OFS_MODE, 32'h0000_0000);
	endtask : t_edge_a

	task t_oneshot;
		logic [15:0] c;
		xfer(1'b1, tmo_pkg::OFS_PRESCALE, 32'h0000_002a);
		xfer(1'b1, tmo_pkg::OFS_OUTCTL, B_TOE | B_OSPE);
		xfer(1'b1, tmo_pkg::OFS_MODE, B_RUN);
		// divide by 32: about twelve count clocks in this wait
		waitc(400);
		xfer(1'b0, tmo_pkg::OFS_STATUS, 32'h0000_0000);
		chk(32'(rdat[15:0] > 16'h0008), 32'h0000_0001);
		xfer(1'b1, tmo_pkg::OFS_OUTCTL, B_TOE | B_OSPE | B_OSPT);
		xfer(1'b0, tmo_pkg::OFS_STATUS, 32'h0000_0000);
		chk(32'(rdat[15:0] < 16'h0005), 32'h0000_0001);
		xfer(1'b0, tmo_pkg::OFS_OUTCTL, 32'h0000_0000);
		chk(rdat, B_TOE | B_OSPE);
		// a second trigger needs two count clock periods of spacing
		// two periods of the divide-by-32 count clock are 64 cycles
		waitc(70);
		xfer(1'b1, tmo_pkg::OFS_OUTCTL, B_TOE | B_OSPE | B_OSPT);
		xfer(1'b0, tmo_pkg::OFS_STATUS, 32'h0000_0000);
		chk(32'(rdat[15:0] < 16'h0005), 32'h0000_0001);
		xfer(1'b1, tmo_pkg::OFS_MODE, 32'h0000_0000);
		xfer(1'b0, tmo_pkg::OFS_STATUS, 32'h0000_0000);
		c = rdat[15:0];
		waitc(10);
		xfer(1'b0, tmo_pkg::OFS_STATUS, 32'h0000_0000);
		chk(32'(rdat[15:0]), 32'(c));
	endtask : t_oneshot

	task t_outlevel;
		xfer(1'b1, tmo_pkg::OFS_OUTCTL, B_TOE);
		xfer(1'b1, tmo_pkg::OFS_OUTCTL, B_TOE | B_LVS);
		xfer(1'b1, tmo_pkg::OFS_OUTCTL, B_TOE);
		waitc(2);
		chk(32'(pin_out), 32'h0000_0001);
		chk(32'(pin_oe), 32'h0000_0001);
		xfer(1'b0, tmo_pkg::OFS_OUTCTL, 32'h0000_0000);
		chk(rdat, B_TOE);
		xfer(1'b1, tmo_pkg::OFS_OUTCTL, B_TOE | B_LVR);
		waitc(2);
		chk(32'(pin_out), 32'h0000_0000);
		xfer(1'b0, tmo_pkg::OFS_OUTCTL, 32'h0000_0000);
		chk(rdat, B_TOE);
	endtask : t_outlevel

	task t_pin_b;
		xfer(1'b1, tmo_pkg::OFS_PRESCALE, 32'h0000_0018);
		xfer(1'b1, tmo_pkg::OFS_OUTCTL, B_TOE | B_LVS);
		xfer(1'b1, tmo_pkg::OFS_MODE, B_RUN | 32'h0000_0010);
		waitc(6);
		chk(32'(pin_oe), 32'h0000_0000);
		xfer(1'b1, tmo_pkg::OFS_STATUS, 32'h0002_0000);
		lvl_b <= 1'b1;
		waitc(6);
		xfer(1'b0, tmo_pkg::OFS_STATUS, 32'h0000_0000);
		chk(32'(rdat[tmo_pkg::ST_EDGE_B]), 32'h0000_0001);
		xfer(1'b1, tmo_pkg::OFS_MODE, 32'h0000_0000);
		waitc(2);
		chk(32'(pin_oe), 32'h0000_0001);
		osc <= 1'b1;
		waitc(4);
		xfer(1'b0, tmo_pkg::OFS_STATUS, 32'h0000_0000);
		chk(32'(rdat[tmo_pkg::ST_OSC]), 32'h0000_0001);
	endtask : t_pin_b

	// clear on compare and clear on input a edge run modes
	task t_run_modes;
		int n;
		logic p;
		xfer(1'b1, tmo_pkg::OFS_PRESCALE, 32'h0000_0009);
		xfer(1'b1, tmo_pkg::OFS_CMP, 32'h0000_0003);
		xfer(1'b1, tmo_pkg::OFS_OUTCTL, B_TOE | B_OSPE);
		// trigger while stopped clears the counter to zero without starting it
		xfer(1'b1, tmo_pkg::OFS_OUTCTL, B_TOE | B_OSPE | B_OSPT);
		xfer(1'b1, tmo_pkg::OFS_OUTCTL, B_TOE | B_INV1);
		xfer(1'b1, tmo_pkg::OFS_MODE,
			32'(tmo_pkg::RUN_CLR_CMP) << tmo_pkg::MD_RUN_LO);
		// compare 3 at divide by 8: output turns every 32 cycles
		waitc(40);
		p = pin_out;
		n = 0;
		repeat (160)
		begin
			@(posedge clk);
			if (pin_out !== p)
			begin
				n++;
				p = pin_out;
			end
		end
		chk(32'(n), 32'h0000_0005);
		xfer(1'b0, tmo_pkg::OFS_STATUS, 32'h0000_0000);
		chk(32'(rdat[15:0] <= 16'h0003), 32'h0000_0001);
		xfer(1'b1, tmo_pkg::OFS_MODE, 32'h0000_0000);
		xfer(1'b1, tmo_pkg::OFS_PRESCALE, 32'h0000_000c);
		xfer(1'b1, tmo_pkg::OFS_MODE,
			32'(tmo_pkg::RUN_CLR_EDGE) << tmo_pkg::MD_RUN_LO);
		waitc(30);
		xfer(1'b0, tmo_pkg::OFS_STATUS, 32'h0000_0000);
		chk(32'(rdat[15:0] > 16'h0008), 32'h0000_0001);
		// a falling edge of input a clears and restarts the counter
		lvl_a <= 1'b0;
		waitc(4);
		xfer(1'b0, tmo_pkg::OFS_STATUS, 32'h0000_0000);
		chk(32'(rdat[15:0] < 16'h0005), 32'h0000_0001);
		xfer(1'b1, tmo_pkg::OFS_MODE, 32'h0000_0000);
	endtask : t_run_modes

	// reset, then the scenarios; edge test first, before any enable
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		lvl_a = 1'b1;
		lvl_b = 1'b0;
		osc = 1'b0;
		waitc(3);
		rst_n <= 1'b1;
		t_reset();
		t_edge_a();
		t_oneshot();
		t_outlevel();
		t_pin_b();
		t_run_modes();
		end_of_test();
	end
endmodule : tmo_timer_out_ctrl_test
